// file: verilog/ppf_pkg.sv
package ppf_pkg;

	// number of ports served by one register nibble
	localparam int PORTS = 4;

	// command codes of the two registers
	localparam logic [7:0] CMD_PRIO_CUT = 8'h15;
	localparam logic [7:0] CMD_TIMING = 8'h16;

	// reset values
	localparam logic [7:0] PRIO_CUT_RST = 8'h00;
	localparam logic [7:0] TIMING_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;

	// clock and fault cool-down time
	localparam int CLK_MHZ = 250;
	localparam int COOL_TIME_MS = 1000;
	localparam int COOL_CYC = COOL_TIME_MS * 1000 * CLK_MHZ;
	localparam int COOL_W = 28;

	// timeout of a 2-bit timing field: base cycles shifted by field code
	localparam int TMO_BASE_CYC = 16;
	localparam int TMO_W = 16;

	// priority register: bits 7-4 shutdown priority, bits 3-0 cut disable
	typedef struct packed {
		logic [PORTS-1:0] shutdown_priority_bits;
		logic [PORTS-1:0] overcurrent_cut_disable_bits;
	} ppf_prio_cut_s;

	// timing register: 7-6 current limit, 5-4 startup, 3-2 overload, 1-0 disconnect
	typedef struct packed {
		logic [1:0] current_limit_timeout_field;
		logic [1:0] startup_timeout_field;
		logic [1:0] overload_timeout_field;
		logic [1:0] disconnect_timeout_field;
	} ppf_timing_s;

	// per-port inputs from the host command decoder and the port engines
	typedef struct packed {
		logic on_req;
		logic pg_sense;
		logic reset_cmd;
		logic cut_over;
		logic lim_active;
		logic lim_tmo;
		logic ovld_tmo;
		logic disc_tmo;
		logic start_tmo;
		logic cut_flag_clr;
	} ppf_port_in_s;

	// per-port status
	typedef struct packed {
		logic power_enable_status_bit;
		logic power_good_status_bit;
		logic overcurrent_cut_fault;
		logic cooldown;
		logic lim_monitor;
	} ppf_port_out_s;

endpackage

// file: verilog/ppf_regfile.sv
`timescale 1ns/1ns
module ppf_regfile
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// host command port
	input wire logic i_cmd_valid,
	input wire logic i_cmd_write,
	input wire logic [7:0] i_cmd_code,
	input wire logic [7:0] i_cmd_wdata,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	// register contents
	output ppf_pkg::ppf_prio_cut_s o_prio_cut,
	output ppf_pkg::ppf_timing_s o_timing
);

	ppf_pkg::ppf_prio_cut_s prio_cut_reg;
	ppf_pkg::ppf_prio_cut_s prio_cut_next;
	ppf_pkg::ppf_timing_s timing_reg;
	ppf_pkg::ppf_timing_s timing_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic rvalid_reg;
	logic rvalid_next;

	always_comb
	begin
		prio_cut_next = prio_cut_reg;
		timing_next = timing_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		if (i_cmd_valid && i_cmd_write)
		begin
			if (i_cmd_code == ppf_pkg::CMD_PRIO_CUT)
				prio_cut_next = i_cmd_wdata;
			else if (i_cmd_code == ppf_pkg::CMD_TIMING)
				timing_next = i_cmd_wdata;
		end
		else if (i_cmd_valid)
		begin
			rvalid_next = 1'b1;
			if (i_cmd_code == ppf_pkg::CMD_PRIO_CUT)
				rdata_next = prio_cut_reg;
			else if (i_cmd_code == ppf_pkg::CMD_TIMING)
				rdata_next = timing_reg;
			else
				rdata_next = ppf_pkg::UNMAPPED_RD;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			prio_cut_reg <= ppf_pkg::PRIO_CUT_RST;
			timing_reg <= ppf_pkg::TIMING_RST;
			rdata_reg <= ppf_pkg::UNMAPPED_RD;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			prio_cut_reg <= prio_cut_next;
			timing_reg <= timing_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign o_prio_cut = prio_cut_reg;
	assign o_timing = timing_reg;
	assign o_rdata = rdata_reg;
	assign o_rvalid = rvalid_reg;

endmodule

// file: verilog/ppf_port_ctl.sv
`timescale 1ns/1ns
// Summary of operation
// - upper nibble picks ports reacting to shutdown
// - priority one: port off; zero: untouched
// - shutdown clears like reset, keeps cool-down
// - cut disable blocks power removal on cut
// - current-limit monitoring stays active regardless
// - disabled cut still flags, timeout half limit
// - timing faults clear power good and enable
// - timing register: four 2-bit fields, reset zero
// - priority register: one byte, read/write, reset zero
module ppf_port_ctl
#(
	parameter int NUM_PORTS = ppf_pkg::PORTS,
	parameter int COOL_CYCLES = ppf_pkg::COOL_CYC,
	parameter int TMO_BASE = ppf_pkg::TMO_BASE_CYC
)
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// host command port
	input wire logic i_cmd_valid,
	input wire logic i_cmd_write,
	input wire logic [7:0] i_cmd_code,
	input wire logic [7:0] i_cmd_wdata,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	// fast shutdown
	input wire logic i_fast_shutdown_input,
	// per-port events and status
	input wire ppf_pkg::ppf_port_in_s [NUM_PORTS-1:0] i_port,
	output ppf_pkg::ppf_port_out_s [NUM_PORTS-1:0] o_port
);

	if (NUM_PORTS != ppf_pkg::PORTS)
	begin : g_bad_ports
		$error("port count must match the register nibble width");
	end
	if (COOL_CYCLES < 1 || COOL_CYCLES >= (1 << ppf_pkg::COOL_W))
	begin : g_bad_cool
		$error("cool-down count out of range");
	end
	if (TMO_BASE < 2 || (TMO_BASE << 3) >= (1 << ppf_pkg::TMO_W))
	begin : g_bad_tmo
		$error("timeout base out of range");
	end

	localparam logic [ppf_pkg::COOL_W-1:0] COOL_LOAD = ppf_pkg::COOL_W'(COOL_CYCLES);
	localparam logic [ppf_pkg::TMO_W-1:0] TMO_BASE_V = ppf_pkg::TMO_W'(TMO_BASE);

	ppf_pkg::ppf_prio_cut_s prio_cut;
	ppf_pkg::ppf_timing_s timing;

	ppf_regfile u_regs
	(
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_cmd_valid(i_cmd_valid),
		.i_cmd_write(i_cmd_write),
		.i_cmd_code(i_cmd_code),
		.i_cmd_wdata(i_cmd_wdata),
		.o_rdata(o_rdata),
		.o_rvalid(o_rvalid),
		.o_prio_cut(prio_cut),
		.o_timing(timing)
	);

	// decodes a 2-bit timing field into a cycle count
	function automatic logic [ppf_pkg::TMO_W-1:0] field_timeout(input logic [1:0] code);
		field_timeout = TMO_BASE_V << code;
	endfunction

	logic [ppf_pkg::TMO_W-1:0] lim_tmo_cyc;
	logic [ppf_pkg::TMO_W-1:0] ovld_tmo_cyc;

	always_comb
	begin
		lim_tmo_cyc = field_timeout(timing.current_limit_timeout_field);
		ovld_tmo_cyc = field_timeout(timing.overload_timeout_field);
	end

	logic [NUM_PORTS-1:0] pe_reg;
	logic [NUM_PORTS-1:0] pe_next;
	logic [NUM_PORTS-1:0] pg_reg;
	logic [NUM_PORTS-1:0] pg_next;
	logic [NUM_PORTS-1:0] cut_flag_reg;
	logic [NUM_PORTS-1:0] cut_flag_next;
	logic [NUM_PORTS-1:0] lim_mon_reg;
	logic [NUM_PORTS-1:0] lim_mon_next;
	logic [ppf_pkg::TMO_W-1:0] cut_cnt_reg [NUM_PORTS];
	logic [ppf_pkg::TMO_W-1:0] cut_cnt_next [NUM_PORTS];
	logic [ppf_pkg::COOL_W-1:0] cool_reg [NUM_PORTS];
	logic [ppf_pkg::COOL_W-1:0] cool_next [NUM_PORTS];

	for (genvar p = 0; p < NUM_PORTS; p++)
	begin : g_port
		logic oss_kill;
		logic cut_dis;
		logic [ppf_pkg::TMO_W-1:0] cut_tmo;
		logic cut_hit;
		logic timing_fault;
		logic off_now;

		always_comb
		begin
			oss_kill = i_fast_shutdown_input
				&& prio_cut.shutdown_priority_bits[p];
			cut_dis = prio_cut.overcurrent_cut_disable_bits[p];
			// disabled cut still times out, at half the limit timeout
			cut_tmo = cut_dis ? (lim_tmo_cyc >> 1) : ovld_tmo_cyc;
			cut_hit = pe_reg[p] && i_port[p].cut_over
				&& (cut_cnt_reg[p] == cut_tmo - 1'b1);
			timing_fault = i_port[p].lim_tmo || i_port[p].ovld_tmo
				|| i_port[p].disc_tmo || i_port[p].start_tmo
				|| (cut_hit && !cut_dis);
			off_now = timing_fault || oss_kill || i_port[p].reset_cmd;

			// cut timer runs only while powered and over threshold
			if (pe_reg[p] && i_port[p].cut_over && cut_cnt_reg[p] < cut_tmo)
				cut_cnt_next[p] = cut_cnt_reg[p] + 1'b1;
			else if (pe_reg[p] && i_port[p].cut_over)
				cut_cnt_next[p] = cut_cnt_reg[p];
			else
				cut_cnt_next[p] = '0;

			// turn-on is held off during cool-down and while shut down
			if (off_now)
				pe_next[p] = 1'b0;
			else if (i_port[p].on_req && cool_reg[p] == '0)
				pe_next[p] = 1'b1;
			else
				pe_next[p] = pe_reg[p];

			if (off_now)
				pg_next[p] = 1'b0;
			else
				pg_next[p] = pe_reg[p] && i_port[p].pg_sense;

			// a new cut event wins over any clear in the same cycle
			if (cut_hit)
				cut_flag_next[p] = 1'b1;
			else if (i_port[p].cut_flag_clr || oss_kill || i_port[p].reset_cmd)
				cut_flag_next[p] = 1'b0;
			else
				cut_flag_next[p] = cut_flag_reg[p];

			// shutdown leaves the cool-down running; reset command cancels it
			if (i_port[p].reset_cmd)
				cool_next[p] = '0;
			else if (timing_fault)
				cool_next[p] = COOL_LOAD;
			else if (cool_reg[p] != '0)
				cool_next[p] = cool_reg[p] - 1'b1;
			else
				cool_next[p] = cool_reg[p];

			// limit monitoring ignores the cut disable bit
			lim_mon_next[p] = pe_reg[p] && i_port[p].lim_active;
		end

		always_ff @(posedge i_clk_sys)
		begin
			if (i_reset)
			begin
				cut_cnt_reg[p] <= '0;
				cool_reg[p] <= '0;
			end
			else
			begin
				cut_cnt_reg[p] <= cut_cnt_next[p];
				cool_reg[p] <= cool_next[p];
			end
		end

		assign o_port[p].power_enable_status_bit = pe_reg[p];
		assign o_port[p].power_good_status_bit = pg_reg[p];
		assign o_port[p].overcurrent_cut_fault = cut_flag_reg[p];
		assign o_port[p].cooldown = (cool_reg[p] != '0);
		assign o_port[p].lim_monitor = lim_mon_reg[p];
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			pe_reg <= '0;
			pg_reg <= '0;
			cut_flag_reg <= '0;
			lim_mon_reg <= '0;
		end
		else
		begin
			pe_reg <= pe_next;
			pg_reg <= pg_next;
			cut_flag_reg <= cut_flag_next;
			lim_mon_reg <= lim_mon_next;
		end
	end

endmodule

// file: tb/ppf_port_ctl_asserts.sv
`timescale 1ns/1ns
module ppf_port_ctl_asserts
#(
	parameter int NUM_PORTS = 4,
	parameter int COOL_CYCLES = 20,
	parameter int TMO_BASE = 16
)
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// host command port
	input wire logic i_cmd_valid,
	input wire logic i_cmd_write,
	input wire logic [7:0] i_cmd_code,
	input wire logic [7:0] i_cmd_wdata,
	input wire logic [7:0] o_rdata,
	input wire logic o_rvalid,
	// shutdown and ports
	input wire logic i_fast_shutdown_input,
	input wire ppf_pkg::ppf_port_in_s [NUM_PORTS-1:0] i_port,
	input wire ppf_pkg::ppf_port_out_s [NUM_PORTS-1:0] o_port
);
	logic [7:0] prio_reg;
	logic [7:0] prio_next;
	logic tmo0;
	logic kill0;
	logic pe;
	// shadow of the priority register, rebuilt from host writes
	always_comb
	begin
		prio_next = prio_reg;
		if (i_cmd_valid && i_cmd_write && i_cmd_code == 8'h15)
			prio_next = i_cmd_wdata;
	end
	always_ff @(posedge i_clk_sys)
		prio_reg <= i_reset ? 8'h00 : prio_next;
	assign pe = o_port[0].power_enable_status_bit;
	assign tmo0 = |{i_port[0].lim_tmo, i_port[0].ovld_tmo, i_port[0].disc_tmo, i_port[0].start_tmo};
	assign kill0 = tmo0 | i_port[0].reset_cmd | (i_fast_shutdown_input & prio_reg[4]);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	AST_RD_UNMAP: assert property (i_cmd_valid && !i_cmd_write && i_cmd_code == 8'h17
		|=> o_rvalid && o_rdata == 8'h00) else $error("unmapped read not zero");
	AST_WR_RD_PRIO: assert property (i_cmd_valid && i_cmd_write && i_cmd_code == 8'h15 ##1
		i_cmd_valid && !i_cmd_write && i_cmd_code == 8'h15 |=> o_rvalid && o_rdata == $past(i_cmd_wdata, 2))
		else $error("priority readback wrong");
	AST_WR_RD_TIM: assert property (i_cmd_valid && i_cmd_write && i_cmd_code == 8'h16 ##1
		i_cmd_valid && !i_cmd_write && i_cmd_code == 8'h16 |=> o_rvalid && o_rdata == $past(i_cmd_wdata, 2))
		else $error("timing readback wrong");
	AST_SHUT_OFF: assert property (i_fast_shutdown_input && prio_reg[4]
		|=> !pe && !o_port[0].power_good_status_bit) else $error("shutdown left port on");
	AST_SHUT_KEEP: assert property (pe && !kill0 && !i_port[0].cut_over |=> pe)
		else $error("port dropped without cause");
	AST_CUT_KEEP: assert property (pe && !kill0 && prio_reg[0] |=> pe)
		else $error("disabled cut removed power");
	AST_TFAULT: assert property (tmo0 |=> !pe && !o_port[0].power_good_status_bit && o_port[0].cooldown)
		else $error("timing fault left status");
	AST_RST_CMD: assert property (i_port[0].reset_cmd && !i_port[0].cut_over |=> !pe && !o_port[0].cooldown)
		else $error("reset command incomplete");
	AST_LIM_MON: assert property (pe && i_port[0].lim_active |=> o_port[0].lim_monitor)
		else $error("limit monitor idle");
	cover property (i_fast_shutdown_input && prio_reg[4] && pe);
	cover property (tmo0 && pe);
	cover property ($rose(o_port[0].overcurrent_cut_fault) && pe);
endmodule
bind ppf_port_ctl ppf_port_ctl_asserts #(.NUM_PORTS(NUM_PORTS), .COOL_CYCLES(COOL_CYCLES),
	.TMO_BASE(TMO_BASE)) u_chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid),
	.i_cmd_write(i_cmd_write), .i_cmd_code(i_cmd_code), .i_cmd_wdata(i_cmd_wdata),
	.o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_fast_shutdown_input(i_fast_shutdown_input),
	.i_port(i_port), .o_port(o_port));

// file: tb/ppf_host.sv
`timescale 1ns/1ns
module ppf_host
(
	// clock and read answer
	input wire logic i_clk_sys,
	input wire logic [7:0] i_rdata,
	// command strobe
	output logic o_valid,
	output logic o_write,
	output logic [7:0] o_code,
	output logic [7:0] o_wdata
);
	initial
	begin
		o_valid = 1'h0;
		o_write = 1'h0;
		o_code = 8'h00;
		o_wdata = 8'h00;
	end
	// strobe stays up so commands can follow each other every edge
	task cmd(input logic wr, input logic [7:0] c, input logic [7:0] d, output logic [7:0] rd);
		o_valid = 1'h1;
		o_write = wr;
		o_code = c;
		o_wdata = d;
		@(posedge i_clk_sys);
		#1;
		rd = i_rdata;
	endtask
	// idle bus shows junk, never the last byte
	task idle;
		o_valid = 1'h0;
		o_code = ~o_code;
		o_wdata = ~o_wdata;
	endtask
endmodule

// file: tb/port_priority_fault_timing_regs_tb.sv
`timescale 1ns/1ns
module port_priority_fault_timing_regs_tb;
	logic clk, rst, shut, v, w, rv;
	logic [7:0] code, wd, rd, got, prio;
	logic [31:0] seed;
	ppf_pkg::ppf_port_in_s [3:0] pin;
	ppf_pkg::ppf_port_out_s [3:0] pout;
	int errors, tests_run, n;
	ppf_port_ctl #(.COOL_CYCLES(20)) DUT (.i_clk_sys(clk), .i_reset(rst), .i_cmd_valid(v),
		.i_cmd_write(w), .i_cmd_code(code), .i_cmd_wdata(wd), .o_rdata(rd), .o_rvalid(rv),
		.i_fast_shutdown_input(shut), .i_port(pin), .o_port(pout));
	ppf_host host (.i_clk_sys(clk), .i_rdata(rd), .o_valid(v), .o_write(w), .o_code(code),
		.o_wdata(wd));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task pulse_all(input int b);
		for (int p = 0; p < 4; p++)
			pin[p][b] = 1'h1;
		tick(1);
		for (int p = 0; p < 4; p++)
			pin[p][b] = 1'h0;
		tick(2);
	endtask
	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		#20000;
		errors++;
		complete_run();
	end
	initial
	begin
		rst = 1'h1;
		shut = 1'h0;
		pin = '0;
		seed = 32'h4;
		tick(8);
		rst = 1'h0;
		for (int c = 8'h15; c <= 8'h17; c++)
		begin
			host.cmd(1'h0, c[7:0], 8'h00, got);
			chk("reset value", got, 8'h00);
			chk("read valid", 8'(rv), 8'h01);
			seed = xs(seed);
			host.cmd(1'h1, c[7:0], seed[7:0], got);
			host.cmd(1'h0, c[7:0], 8'h00, got);
			chk("read back", got, c == 8'h17 ? 8'h00 : seed[7:0]);
		end
		$display("test registers done");
		prio = {seed[11:8], 4'hf};
		host.cmd(1'h1, 8'h15, prio, got);
		host.idle();
		for (int p = 0; p < 4; p++)
			pin[p].pg_sense = 1'h1;
		pulse_all(9);
		shut = 1'h1;
		tick(2);
		for (int p = 0; p < 4; p++)
			chk("shutdown pe", 8'(pout[p].power_enable_status_bit), 8'(!prio[4 + p]));
		shut = 1'h0;
		$display("test shutdown done");
		pulse_all(9);
		for (int p = 0; p < 4; p++)
			pin[p][4 - p] = 1'h1;
		tick(1);
		pin = '0;
		tick(1);
		for (int p = 0; p < 4; p++)
			chk("fault status", 8'({pout[p].power_enable_status_bit, pout[p].power_good_status_bit,
				pout[p].cooldown}), 8'h01);
		host.cmd(1'h1, 8'h15, 8'h1f, got);
		host.idle();
		shut = 1'h1;
		tick(4);
		chk("cooldown kept", 8'(pout[0].cooldown), 8'h01);
		shut = 1'h0;
		pulse_all(7);
		chk("cooldown cleared", 8'(pout[0].cooldown), 8'h00);
		$display("test faults done");
		host.cmd(1'h1, 8'h16, 8'h48, got);
		host.cmd(1'h1, 8'h15, 8'h01, got);
		host.idle();
		for (int p = 0; p < 4; p++)
			pin[p].pg_sense = 1'h1;
		pulse_all(9);
		for (int p = 0; p < 2; p++)
			{pin[p].cut_over, pin[p].lim_active} = 2'h3;
		n = 0;
		while (pout[0].overcurrent_cut_fault !== 1'h1 && n < 100)
		begin
			tick(1);
			n++;
		end
		chk("cut flag time", 8'(n >= 14 && n <= 18), 8'h01);
		tick(1);
		chk("cut disabled pe", 8'(pout[0].power_enable_status_bit), 8'h01);
		chk("limit monitor", 8'(pout[0].lim_monitor), 8'h01);
		tick(60);
		chk("cut enabled pe", 8'(pout[1].power_enable_status_bit), 8'h00);
		chk("cut enabled flag", 8'(pout[1].overcurrent_cut_fault), 8'h01);
		// counter has passed its hit point, so the clear is not overridden
		pulse_all(0);
		chk("cut flag clear", 8'(pout[0].overcurrent_cut_fault), 8'h00);
		pin = '0;
		$display("test cut done");
		complete_run();
	end
endmodule
